// ---- design/ssp_top.sv ----
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
// Function
// - port runs in one SPI/I2C mode only
// - status at 94h, upper bits RW
// - control at 14h, all RW, reset zero
// - control: collision, overflow, enable, polarity, mode
// - buffer write during shift sets collision
// - slave byte arriving over unread sets overflow
// - overflow discards new byte, keeps buffer
// - overflow raised only as slave
// - master mode never sets overflow
// - direction bit valid match to start/stop/nack
// - mode selects master clock source
// - enable hands pins to the port
// - polarity sets idle clock level
// - full byte loads buffer, sets flags
module ssp_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic ss_n_in,
  input wire logic timer_two_tick,
  input wire logic i2c_start_seen,
  input wire logic i2c_stop_seen,
  input wire logic i2c_addr_match,
  input wire logic i2c_rw_bit,
  input wire logic i2c_nack,
  output logic port_pins_owned,
  output logic irq
);
  import ssp_pkg::*;
  logic [7:0] serial_control_reg;
  logic [7:0] serial_status_reg;
  logic [7:0] serial_buffer_reg;
  logic [7:0] serial_shift_reg;
  logic [7:0] address_match_reg;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  ssp_state_t state;
  logic [3:0] bit_cnt;
  logic [5:0] div_cnt;
  logic t2_half;
  logic sck_s, sck_rise, sck_fall, sdi_s, ss_s;
  logic ph_wr, ph_rd;
  logic [7:0] ph_addr;

  ssp_sync u_sck (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(sck_in),
    .dout(sck_s), .rise(sck_rise), .fall(sck_fall));
  ssp_sync u_sdi (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(sdi_in),
    .dout(sdi_s), .rise(), .fall());
  ssp_sync u_ss (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(ss_n_in),
    .dout(ss_s), .rise(), .fall());

  // decoded mode
  wire [3:0] port_mode_select = serial_control_reg[3:0];
  wire port_enable_bit = serial_control_reg[SSP_CTL_EN];
  wire clock_polarity_bit = serial_control_reg[SSP_CTL_POL];
  wire sample_phase_bit = serial_status_reg[SSP_ST_SAMPLE];
  wire edge_sel = serial_status_reg[SSP_ST_CKE];
  wire is_master = port_enable_bit && (port_mode_select <= SSP_MODE_MT2);
  wire is_slave = port_enable_bit &&
    (port_mode_select == SSP_MODE_S_SS || port_mode_select == SSP_MODE_S_NOSS);
  wire is_i2c = port_enable_bit && !is_master && !is_slave;
  wire ss_block = (port_mode_select == SSP_MODE_S_SS) && ss_s;
  wire [5:0] half_div = (port_mode_select == SSP_MODE_M4) ? SSP_HALF_DIV4 :
    (port_mode_select == SSP_MODE_M16) ? SSP_HALF_DIV16 : SSP_HALF_DIV64;
  wire use_t2 = port_mode_select == SSP_MODE_MT2;
  wire busy = state != SSP_IDLE;

  // bus decode
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_ctl = ph_wr && ph_addr == SSP_ADDR_CONTROL;
  wire wr_st = ph_wr && ph_addr == SSP_ADDR_STATUS;
  wire wr_buf = ph_wr && ph_addr == SSP_ADDR_BUFFER;
  wire wr_adr = ph_wr && ph_addr == SSP_ADDR_ADDRESS;
  wire wr_ist = ph_wr && ph_addr == SSP_ADDR_IRQ_STATUS;
  wire wr_msk = ph_wr && ph_addr == SSP_ADDR_IRQ_MASK;
  wire rd_buf_now = addr_phase && !hwrite && haddr == SSP_ADDR_BUFFER;
  wire [7:0] rd_mux = (haddr == SSP_ADDR_CONTROL) ? serial_control_reg :
    (haddr == SSP_ADDR_STATUS) ? serial_status_reg :
    (haddr == SSP_ADDR_BUFFER) ? serial_buffer_reg :
    (haddr == SSP_ADDR_ADDRESS) ? address_match_reg :
    (haddr == SSP_ADDR_IRQ_STATUS) ? {4'h0, irq_status} :
    (haddr == SSP_ADDR_IRQ_MASK) ? {4'h0, irq_mask} : 8'h00;

  // shift-clock edges: master uses the divider, slave the synchronised pin
  wire div_hit = use_t2 ? (timer_two_tick && t2_half) : (div_cnt == half_div - 6'h01);
  wire m_tick = is_master && busy && div_hit;
  wire s_lead = is_slave && !ss_block && (clock_polarity_bit ? sck_fall : sck_rise);
  wire s_trail = is_slave && !ss_block && (clock_polarity_bit ? sck_rise : sck_fall);
  wire lead_edge = m_tick ? (state == SSP_LEAD) : s_lead;
  wire trail_edge = m_tick ? (state == SSP_TRAIL) : s_trail;
  // cke=1 shifts data out on the leading edge and samples on the trailing one
  // master samples at its trailing edge: the synchronised data pin lags two cycles
  wire sample_edge = (edge_sel || is_master) ? trail_edge : lead_edge;
  wire out_edge = edge_sel ? lead_edge : trail_edge;
  wire byte_done = sample_edge && bit_cnt == SSP_BITS - 4'h1;
  wire trail_done = sample_edge ? byte_done : (bit_cnt == 4'h0);
  wire collision = wr_buf && busy;
  wire overflow = byte_done && is_slave && serial_status_reg[SSP_ST_FULL];
  wire byte_load = byte_done && !overflow;
  wire [7:0] shifted = {serial_shift_reg[6:0], sdi_s};
  wire [3:0] irq_events = {collision | overflow, overflow, collision, byte_done};

  // bus slave: zero-wait, OKAY
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      ph_wr <= addr_phase && hwrite;
      ph_addr <= haddr;
      if (addr_phase && !hwrite) hrdata <= {24'h00_0000, rd_mux};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) serial_control_reg <= SSP_CONTROL_RESET;
    else begin
      if (wr_ctl) serial_control_reg <= hwdata[7:0];
      if (collision) serial_control_reg[SSP_CTL_COLL] <= 1'b1;
      if (overflow) serial_control_reg[SSP_CTL_ROV] <= 1'b1;
    end
  end

  // status register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) serial_status_reg <= SSP_STATUS_RESET;
    else begin
      if (wr_st) serial_status_reg[SSP_ST_SAMPLE:SSP_ST_CKE] <= hwdata[7:6];
      if (!port_enable_bit) begin
        serial_status_reg[SSP_ST_STOP] <= 1'b0;
        serial_status_reg[SSP_ST_START] <= 1'b0;
      end else if (is_i2c && i2c_start_seen) begin
        serial_status_reg[SSP_ST_START] <= 1'b1;
        serial_status_reg[SSP_ST_STOP] <= 1'b0;
      end else if (is_i2c && i2c_stop_seen) begin
        serial_status_reg[SSP_ST_STOP] <= 1'b1;
        serial_status_reg[SSP_ST_START] <= 1'b0;
      end
      if (is_i2c && (i2c_start_seen || i2c_stop_seen || i2c_nack))
        serial_status_reg[SSP_ST_RW] <= 1'b0;
      else if (is_i2c && i2c_addr_match)
        serial_status_reg[SSP_ST_RW] <= i2c_rw_bit;
      if (wr_adr) serial_status_reg[SSP_ST_ADDR_UPD] <= 1'b0;
      if (is_i2c && i2c_addr_match) serial_status_reg[SSP_ST_ADDR_UPD] <= 1'b1;
      serial_status_reg[SSP_ST_DA] <= 1'b0;
      if (rd_buf_now) serial_status_reg[SSP_ST_FULL] <= 1'b0;
      if (byte_load) serial_status_reg[SSP_ST_FULL] <= 1'b1;
    end
  end

  // buffer, address and shift path
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_buffer_reg <= 8'h00;
      address_match_reg <= 8'h00;
    end else begin
      if (wr_adr) address_match_reg <= hwdata[7:0];
      if (byte_load) serial_buffer_reg <= shifted;
      else if (wr_buf && !busy) serial_buffer_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_shift_reg <= 8'h00;
      bit_cnt <= 4'h0;
      state <= SSP_IDLE;
    end else if (!port_enable_bit || is_i2c) begin
      bit_cnt <= 4'h0;
      state <= SSP_IDLE;
    end else begin
      if (wr_buf && !busy) begin
        serial_shift_reg <= hwdata[7:0];
        bit_cnt <= 4'h0;
        state <= SSP_LEAD;
      end else begin
        if (sample_edge) serial_shift_reg <= shifted;
        if (sample_edge) bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
        case (state)
          SSP_IDLE: if (is_slave && s_lead) state <= SSP_TRAIL;
          SSP_LEAD: if (lead_edge) state <= SSP_TRAIL;
          SSP_TRAIL: if (trail_edge) state <= trail_done ? SSP_IDLE : SSP_LEAD;
          default: state <= SSP_IDLE;
        endcase
      end
    end
  end

  // master clock divider
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt <= 6'h00;
      t2_half <= 1'b0;
    end else begin
      div_cnt <= (!busy || div_hit) ? 6'h00 : div_cnt + 6'h01;
      if (timer_two_tick) t2_half <= ~t2_half;
    end
  end

  // pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      port_pins_owned <= 1'b0;
    end else begin
      port_pins_owned <= port_enable_bit;
      sck_oe <= is_master;
      sdo_oe <= is_master || (is_slave && !ss_block);
      sck_out <= clock_polarity_bit ^ (is_master && state == SSP_TRAIL);
      if (wr_buf && !busy) sdo_out <= hwdata[7];
      else if (out_edge) sdo_out <= sample_edge ? shifted[7] : serial_shift_reg[7];
    end
  end

  // interrupts: sticky, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_ist ? hwdata[3:0] : 4'h0)) | irq_events;
      if (wr_msk) irq_mask <= hwdata[3:0];
      irq <= |(irq_status & irq_mask);
    end
  end
  wire unused_ok = sample_phase_bit & sck_s & (|hsize);
endmodule

// ---- design/ssp_pkg.sv ----
package ssp_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] SSP_ADDR_CONTROL = 8'h14;
  localparam logic [7:0] SSP_ADDR_STATUS = 8'h94;
  localparam logic [7:0] SSP_ADDR_BUFFER = 8'h20;
  localparam logic [7:0] SSP_ADDR_ADDRESS = 8'h24;
  localparam logic [7:0] SSP_ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] SSP_ADDR_IRQ_MASK = 8'h2C;
  // control field positions
  localparam int SSP_CTL_COLL = 7;
  localparam int SSP_CTL_ROV = 6;
  localparam int SSP_CTL_EN = 5;
  localparam int SSP_CTL_POL = 4;
  // status field positions
  localparam int SSP_ST_SAMPLE = 7;
  localparam int SSP_ST_CKE = 6;
  localparam int SSP_ST_DA = 5;
  localparam int SSP_ST_STOP = 4;
  localparam int SSP_ST_START = 3;
  localparam int SSP_ST_RW = 2;
  localparam int SSP_ST_ADDR_UPD = 1;
  localparam int SSP_ST_FULL = 0;
  // interrupt status bits
  localparam int SSP_IRQ_BYTE = 0;
  localparam int SSP_IRQ_COLL = 1;
  localparam int SSP_IRQ_ROV = 2;
  localparam int SSP_IRQ_W = 3;
  localparam logic [7:0] SSP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SSP_STATUS_RESET = 8'h00;
  // mode select encodings
  localparam logic [3:0] SSP_MODE_M4 = 4'h0;
  localparam logic [3:0] SSP_MODE_M16 = 4'h1;
  localparam logic [3:0] SSP_MODE_M64 = 4'h2;
  localparam logic [3:0] SSP_MODE_MT2 = 4'h3;
  localparam logic [3:0] SSP_MODE_S_SS = 4'h4;
  localparam logic [3:0] SSP_MODE_S_NOSS = 4'h5;
  // half-period of the shift clock in reference cycles: osc/4 -> 2 per half
  localparam logic [5:0] SSP_HALF_DIV4 = 6'h02;
  localparam logic [5:0] SSP_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SSP_HALF_DIV64 = 6'h20;
  localparam logic [3:0] SSP_BITS = 4'h8;
  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_t;
endpackage

// ---- design/ssp_sync.sv ----
`timescale 1ns/1ns
// two-flop synchroniser with edge detection on the second stage
module ssp_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stage;
  logic last;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      stage <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= din;
      stage <= meta;
      last <= stage;
    end
  end
  assign dout = stage;
  assign rise = stage & ~last;
  assign fall = ~stage & last;
endmodule

// ---- test/ssp_top_asserts.sv ----
`timescale 1ns/1ns
module ssp_top_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic port_pins_owned,
  input wire logic irq
);
  import ssp_pkg::*;
  logic ap, aw, mst, wc;
  logic [7:0] aa, msk;
  logic [5:0] ctl;
  logic [1:0] sth;
  wire wr_c = ap && aw && aa == SSP_ADDR_CONTROL;
  wire rd_c = ap && !aw && aa == SSP_ADDR_CONTROL;
  wire rd_s = ap && !aw && aa == SSP_ADDR_STATUS;
  wire wr_s = ap && aw && aa == SSP_ADDR_STATUS;
  wire wr_m = ap && aw && aa == SSP_ADDR_IRQ_MASK;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // shadow of what software wrote, data phase follows address phase at once
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ap <= 1'b0;
      aw <= 1'b0;
      aa <= 8'h00;
      ctl <= 6'h00;
      sth <= 2'h0;
      msk <= 8'h00;
      mst <= 1'b0;
      wc <= 1'b0;
    end else begin
      ap <= hsel & hready & htrans[1];
      aw <= hwrite;
      aa <= haddr;
      if (wr_c) ctl <= hwdata[5:0];
      if (wr_c) mst <= !hwdata[6] && hwdata[3:2] == 2'h0;
      if (wr_s) sth <= hwdata[7:6];
      if (wr_m) msk <= hwdata[7:0];
      if (wr_c) wc <= 1'b0;
      else if (rd_c && hrdata[7]) wc <= 1'b1;
    end
  end
  property p_st_hi; rd_s |-> hrdata[7:6] == sth; endproperty
  a_st_hi: assert property (p_st_hi) else $error("status upper bits differ");
  property p_ctl; rd_c |-> hrdata[5:0] == ctl; endproperty
  a_ctl: assert property (p_ctl) else $error("control readback differs");
  property p_own; port_pins_owned != ctl[5] |=> port_pins_owned == ctl[5]; endproperty
  a_own: assert property (p_own) else $error("pin ownership lags enable");
  property p_oe; !port_pins_owned [*2] |-> !sck_oe && !sdo_oe; endproperty
  a_oe: assert property (p_oe) else $error("pins driven while disabled");
  property p_irq; msk == 8'h00 [*2] |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq with all masked");
  property p_rov; rd_c && mst |-> !hrdata[6]; endproperty
  a_rov: assert property (p_rov) else $error("overflow in master mode");
  property p_write_collision_flag; rd_c && wc |-> hrdata[7]; endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag lost");
  property p_dis; rd_s && !ctl[5] |-> hrdata[4:3] == 2'h0; endproperty
  a_dis: assert property (p_dis) else $error("start or stop kept when off");
endmodule
bind ssp_top ssp_top_asserts i_ssp_top_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
  .port_pins_owned(port_pins_owned), .irq(irq));

// ---- test/ssp_partner.sv ----
`timescale 1ns/1ns
module ssp_partner (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_out,
  output logic sck_in,
  output logic sdi_in,
  output logic ss_n_in
);
  logic [7:0] rep = 8'h3C;
  logic [7:0] got = 8'h00;
  logic drv = 1'b0;
  logic mbit = 1'b0;
  // reply inverts each bit as it leaves, so released data keeps changing
  assign sdi_in = drv ? mbit : rep[7];
  initial begin
    sck_in = 1'b0;
    ss_n_in = 1'b1;
  end
  always @(posedge sck_out) if (sck_oe) got <= {got[6:0], sdo_out};
  always @(negedge sck_out) if (sck_oe) rep <= {rep[6:0], ~rep[7]};
  task automatic send(input logic [7:0] b);
    ss_n_in = 1'b0;
    drv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      mbit = b[i];
      #62 sck_in = 1'b1;
      #63 sck_in = 1'b0;
    end
    #62 drv = 1'b0;
    ss_n_in = 1'b1;
  endtask
endmodule

// ---- test/sync_serial_port_status_control_tb.sv ----
`timescale 1ns/1ns
module sync_serial_port_status_control_tb;
  import ssp_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe;
  logic ss_n_in, port_pins_owned, irq;
  logic i2c_start_seen = 1'b0, i2c_stop_seen = 1'b0;
  logic i2c_addr_match = 1'b0, i2c_rw_bit = 1'b0;
  logic i2c_nack = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int hi_cnt = 0;
  int h0;
  logic [7:0] q;
  ssp_top i_ssp_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .ss_n_in(ss_n_in), .timer_two_tick(1'b0),
    .i2c_start_seen(i2c_start_seen), .i2c_stop_seen(i2c_stop_seen),
    .i2c_addr_match(i2c_addr_match), .i2c_rw_bit(i2c_rw_bit), .i2c_nack(i2c_nack),
    .port_pins_owned(port_pins_owned), .irq(irq));
  ssp_partner i_ssp_partner (.sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
    .sck_in(sck_in), .sdi_in(sdi_in), .ss_n_in(ss_n_in));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) hi_cnt <= hi_cnt + int'(sck_oe & sck_out);
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    ck(q, e);
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge ref_clk);
    {i2c_nack, i2c_addr_match, i2c_stop_seen, i2c_start_seen} <= k;
    i2c_rw_bit <= k[2];
    @(posedge ref_clk);
    {i2c_nack, i2c_addr_match, i2c_stop_seen, i2c_start_seen} <= 4'h0;
  endtask
  initial begin
    #300000;
    fails++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(SSP_ADDR_CONTROL, SSP_CONTROL_RESET);
    ck(hresp, 1'b0);
    rc(SSP_ADDR_STATUS, SSP_STATUS_RESET);
    rc(8'h40, 8'h00);
    xfer(SSP_ADDR_STATUS, 1'b1, 8'hFF);
    rc(SSP_ADDR_STATUS, 8'hC0);
    xfer(SSP_ADDR_STATUS, 1'b1, 8'h00);
    for (int m = 0; m < 6; m++) begin
      xfer(SSP_ADDR_CONTROL, 1'b1, 8'h10 | 8'(m));
      rc(SSP_ADDR_CONTROL, 8'h10 | 8'(m));
    end
    xfer(SSP_ADDR_CONTROL, 1'b1, 8'h00);
    xfer(SSP_ADDR_IRQ_MASK, 1'b1, 8'h01);
    for (int m = 0; m < 3; m++) begin
      xfer(SSP_ADDR_CONTROL, 1'b1, 8'h20 | 8'(m));
      h0 = hi_cnt;
      xfer(SSP_ADDR_BUFFER, 1'b1, 8'hA5);
      if (m == 0) xfer(SSP_ADDR_BUFFER, 1'b1, 8'h5A);
      do xfer(SSP_ADDR_IRQ_STATUS, 1'b0, 8'h00); while (q[0] !== 1'b1);
      ck(irq, 1);
      ck(hi_cnt - h0, 16 << (2 * m));
      ck(i_ssp_partner.got, 8'hA5);
      ck(port_pins_owned, 1);
      ck(sdo_oe, 1);
      xfer(SSP_ADDR_IRQ_STATUS, 1'b1, 8'h0F);
      repeat (2) @(posedge ref_clk);
      ck(irq, 0);
      if (m == 0) begin
        rc(SSP_ADDR_CONTROL, 8'hA0);
        rc(SSP_ADDR_CONTROL, 8'hA0);
        xfer(SSP_ADDR_CONTROL, 1'b1, 8'h20);
        rc(SSP_ADDR_BUFFER, 8'h3C);
        rc(SSP_ADDR_STATUS, 8'h00);
      end
      if (m == 2) rc(SSP_ADDR_CONTROL, 8'h22);
    end
    xfer(SSP_ADDR_BUFFER, 1'b0, 8'h00);
    xfer(SSP_ADDR_CONTROL, 1'b1, 8'h30);
    repeat (3) @(posedge ref_clk);
    ck(sck_out, 1);
    xfer(SSP_ADDR_CONTROL, 1'b1, 8'h24);
    i_ssp_partner.send(8'h96);
    do xfer(SSP_ADDR_STATUS, 1'b0, 8'h00); while (q[0] !== 1'b1);
    ck(sck_oe, 0);
    i_ssp_partner.send(8'h69);
    do xfer(SSP_ADDR_IRQ_STATUS, 1'b0, 8'h00); while (q[2] !== 1'b1);
    rc(SSP_ADDR_CONTROL, 8'h64);
    rc(SSP_ADDR_BUFFER, 8'h96);
    rc(SSP_ADDR_STATUS, 8'h00);
    ck(sdo_oe, 0);
    xfer(SSP_ADDR_CONTROL, 1'b1, 8'h26);
    pulse(4'h4);
    rc(SSP_ADDR_STATUS, 8'h06);
    pulse(4'h8);
    rc(SSP_ADDR_STATUS, 8'h02);
    pulse(4'h4);
    xfer(SSP_ADDR_ADDRESS, 1'b1, 8'h42);
    rc(SSP_ADDR_ADDRESS, 8'h42);
    rc(SSP_ADDR_STATUS, 8'h04);
    pulse(4'h1);
    rc(SSP_ADDR_STATUS, 8'h08);
    pulse(4'h2);
    rc(SSP_ADDR_STATUS, 8'h10);
    xfer(SSP_ADDR_CONTROL, 1'b1, 8'h06);
    rc(SSP_ADDR_STATUS, 8'h00);
    ck(port_pins_owned, 0);
    conclude;
  end
endmodule
